// >>> hw/brt_defs.svh
// constants for the boundary-run test engine
`ifndef BRT_DEFS_SVH
`define BRT_DEFS_SVH
`define BRT_OFF_CTRL      6'h00
`define BRT_OFF_STATUS    6'h01
`define BRT_OFF_BSR_LO    6'h02
`define BRT_OFF_BSR_HI    6'h03
`define BRT_OFF_SHD_LO    6'h04
`define BRT_OFF_SHD_HI    6'h05
`define BRT_CTRL_OP_MSB   2
`define BRT_CTRL_RUN_TEST_INSTRUCTION_BIT 3
`define BRT_CTRL_RST      4'h0
`define BRT_OE1_AB_BIT    11
`define BRT_OE1_BA_BIT    10
`define BRT_OE2_AB_BIT    9
`define BRT_OE2_BA_BIT    8
`define BRT_CTL_RST       12'hF00
`define BRT_IO_RST        36'h0_0000_0000
`define BRT_TAP36         36'h8_0100_0000
`define BRT_TAP18         18'h2_0400
`endif

// >>> hw/brt_pkg.sv
// types for the boundary-run test engine
package brt_pkg;
    typedef enum logic [2:0] {
        BRT_IDLE,
        BRT_TOGGLE,
        BRT_PAT36,
        BRT_SIG36,
        BRT_SIGPAT,
        BRT_SIGCNT
    } brt_mode_t;
    typedef struct packed {
        logic [17:0] b;
        logic [17:0] a;
    } brt_io_t;
endpackage

// >>> hw/brt_sync.sv
// two-flop synchroniser for pins from outside the ref_clk domain
module brt_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             resetn,
    // levels
    input  wire logic [WIDTH-1:0] din,
    output      logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta_q;
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            meta_q <= '0;
            dout   <= '0;
        end else begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end
endmodule

// >>> hw/brt_engine.sv
// boundary-run test engine with classic wishbone register access
`include "brt_defs.svh"
module brt_engine
    import brt_pkg::*;
#(
    parameter logic [35:0] TAP36 = `BRT_TAP36,
    parameter logic [17:0] TAP18 = `BRT_TAP18
) (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output      logic [31:0] wb_dat_o,
    output      logic        wb_ack_o,
    // test access pins and tap state from the tap controller
    input  wire logic        tck,
    input  wire logic        tdi,
    input  wire logic        tap_run_idle,
    input  wire logic        tap_capture_dr,
    input  wire logic        tap_shift_dr,
    output      logic        tdo,
    output      logic        tdo_oe,
    // a-side and b-side io pins
    input  wire logic [17:0] a_in,
    output      logic [17:0] a_out,
    output      logic [17:0] a_oe,
    input  wire logic [17:0] b_in,
    output      logic [17:0] b_out,
    output      logic [17:0] b_oe
);
    // shift one step, new bit enters at the bottom
    function automatic logic [35:0] lfsr36(input logic [35:0] v);
        lfsr36 = {v[34:0], ^(v & TAP36)};
    endfunction

    function automatic logic [17:0] lfsr18(input logic [17:0] v);
        lfsr18 = {v[16:0], ^(v & TAP18)};
    endfunction

    function automatic brt_mode_t decode(input logic [2:0] op);
        case (op)
            3'h3:    decode = BRT_SIGPAT;
            3'h7:    decode = BRT_SIGCNT;
            default: begin
                case (op[1:0])
                    2'h0:    decode = BRT_TOGGLE;
                    2'h1:    decode = BRT_PAT36;
                    default: decode = BRT_SIG36;
                endcase
            end
        endcase
    endfunction

    // synchronised pins
    logic [40:0] sync_out;
    logic [17:0] a_s;
    logic [17:0] b_s;
    logic        tck_s;
    logic        tdi_s;
    logic        run_idle_s;
    logic        capture_s;
    logic        shift_s;

    brt_sync #(
        .WIDTH (41)
    ) u_sync (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .din     ({a_in, b_in, tck, tdi, tap_run_idle, tap_capture_dr,
                   tap_shift_dr}),
        .dout    (sync_out)
    );

    assign {a_s, b_s, tck_s, tdi_s, run_idle_s, capture_s, shift_s} =
        sync_out;

    // state
    logic        ack_q,      ack_d;
    logic [31:0] dat_q,      dat_d;
    logic [2:0]  op_q,       op_d;
    logic        run_test_instruction_q,     run_test_instruction_d;
    brt_io_t     sh_io_q,    sh_io_d;
    logic [11:0] sh_ctl_q,   sh_ctl_d;
    brt_io_t     sd_io_q,    sd_io_d;
    logic [11:0] sd_ctl_q,   sd_ctl_d;
    logic        byp_q,      byp_d;
    logic        tdo_q,      tdo_d;
    logic        tdo_oe_q,   tdo_oe_d;
    logic [17:0] a_oe_q,     a_oe_d;
    logic [17:0] b_oe_q,     b_oe_d;
    logic        tck_prev_q;

    // decoded conditions
    logic        tck_rise;
    logic        tck_fall;
    logic        dir_ok;
    logic        dir_ab;
    logic        running;
    brt_mode_t   mode;
    logic        wr;
    logic [5:0]  idx;

    assign tck_rise = tck_s & ~tck_prev_q;
    assign tck_fall = ~tck_s & tck_prev_q;
    // direction read from the output-enable shadows (active low)
    assign dir_ok = (sd_ctl_q[`BRT_OE1_AB_BIT] != sd_ctl_q[`BRT_OE1_BA_BIT])
        && (sd_ctl_q[`BRT_OE1_AB_BIT] == sd_ctl_q[`BRT_OE2_AB_BIT])
        && (sd_ctl_q[`BRT_OE1_BA_BIT] == sd_ctl_q[`BRT_OE2_BA_BIT]);
    assign dir_ab  = ~sd_ctl_q[`BRT_OE1_AB_BIT];
    assign running = run_test_instruction_q & run_idle_s & dir_ok;
    assign mode    = running ? decode(op_q) : BRT_IDLE;
    assign idx     = wb_adr_i[7:2];
    // write lands on the edge where the master sees ack
    assign wr      = wb_cyc_i & wb_stb_i & wb_we_i & ack_q;

    // register bus and control
    always_comb begin
        ack_d  = wb_cyc_i & wb_stb_i & ~ack_q;
        dat_d  = 32'h0000_0000;
        op_d   = op_q;
        run_test_instruction_d = run_test_instruction_q;
        case (idx)
            `BRT_OFF_CTRL:   dat_d = {28'h000_0000, run_test_instruction_q, op_q};
            `BRT_OFF_STATUS: dat_d = {28'h000_0000, run_idle_s, run_test_instruction_q,
                                      ~dir_ok, running};
            `BRT_OFF_BSR_LO: dat_d = sh_io_q[31:0];
            `BRT_OFF_BSR_HI: dat_d = {16'h0000, sh_ctl_q, sh_io_q[35:32]};
            `BRT_OFF_SHD_LO: dat_d = sd_io_q[31:0];
            `BRT_OFF_SHD_HI: dat_d = {16'h0000, sd_ctl_q, sd_io_q[35:32]};
            default:         dat_d = 32'h0000_0000;
        endcase
        if (wr && idx == `BRT_OFF_CTRL && wb_sel_i[0]) begin
            op_d   = wb_dat_i[`BRT_CTRL_OP_MSB:0];
            run_test_instruction_d = wb_dat_i[`BRT_CTRL_RUN_TEST_INSTRUCTION_BIT];
        end
    end

    // boundary cells, bypass path and pin enables
    logic [35:0] vec;
    logic [17:0] pin_in;
    logic [17:0] out_c;
    logic [17:0] in_c;
    logic [35:0] nxt;
    logic        upd_out;

    always_comb begin
        sh_io_d  = sh_io_q;
        sh_ctl_d = sh_ctl_q;
        sd_io_d  = sd_io_q;
        sd_ctl_d = sd_ctl_q;
        byp_d    = byp_q;
        tdo_d    = tdo_q;
        tdo_oe_d = tdo_oe_q;
        // cell order flips with direction: output cells on top
        vec      = dir_ab ? {sh_io_q.b, sh_io_q.a}
                          : {sh_io_q.a, sh_io_q.b};
        pin_in   = dir_ab ? a_s : b_s;
        out_c    = vec[35:18];
        in_c     = vec[17:0];
        nxt      = vec;
        upd_out  = 1'b1;
        case (mode)
            BRT_TOGGLE: nxt = {~out_c, pin_in};
            BRT_PAT36:  nxt = lfsr36(vec);
            BRT_SIG36: begin
                nxt     = lfsr36(vec) ^ {18'h0_0000, pin_in};
                upd_out = 1'b0;
            end
            BRT_SIGPAT: nxt = {lfsr18(out_c),
                               lfsr18(in_c) ^ pin_in};
            BRT_SIGCNT: nxt = {out_c + 18'h0_0001,
                               lfsr18(in_c) ^ pin_in};
            default:    nxt = vec;
        endcase
        // only stepped while running, so the result freezes on exit
        if (tck_rise && mode != BRT_IDLE) begin
            sh_io_d = dir_ab ? brt_io_t'({nxt[35:18], nxt[17:0]})
                             : brt_io_t'({nxt[17:0], nxt[35:18]});
        end
        // falling edge copies output-mode cells to their shadows in every running mode but BRT_SIG36
        if (tck_fall && mode != BRT_IDLE && upd_out) begin
            if (dir_ab) begin
                sd_io_d.b = sh_io_q.b;
            end else begin
                sd_io_d.a = sh_io_q.a;
            end
        end
        // software seed acts as scan plus update, refused while running
        if (wr && !running && idx == `BRT_OFF_BSR_LO) begin
            sh_io_d[31:0] = wb_dat_i;
            sd_io_d[31:0] = wb_dat_i;
        end
        if (wr && !running && idx == `BRT_OFF_BSR_HI) begin
            sh_io_d[35:32] = wb_dat_i[3:0];
            sd_io_d[35:32] = wb_dat_i[3:0];
            sh_ctl_d       = wb_dat_i[15:4];
            sd_ctl_d       = wb_dat_i[15:4];
        end
        // one-bit bypass path
        if (tck_rise && run_test_instruction_q) begin
            if (capture_s) begin
                byp_d = 1'b0;
            end else if (shift_s) begin
                byp_d = tdi_s;
            end
        end
        if (tck_fall) begin
            tdo_d    = byp_q;
            tdo_oe_d = run_test_instruction_q & shift_s;
        end
        // test mode drives only when direction is legal
        a_oe_d = '0;
        b_oe_d = '0;
        if (run_test_instruction_q && dir_ok) begin
            b_oe_d = {{9{~sd_ctl_q[`BRT_OE2_AB_BIT]}},
                      {9{~sd_ctl_q[`BRT_OE1_AB_BIT]}}};
            a_oe_d = {{9{~sd_ctl_q[`BRT_OE2_BA_BIT]}},
                      {9{~sd_ctl_q[`BRT_OE1_BA_BIT]}}};
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ack_q      <= 1'b0;
            dat_q      <= 32'h0000_0000;
            op_q       <= 3'(`BRT_CTRL_RST);
            run_test_instruction_q     <= 1'b0;
            sh_io_q    <= `BRT_IO_RST;
            sh_ctl_q   <= `BRT_CTL_RST;
            sd_io_q    <= `BRT_IO_RST;
            sd_ctl_q   <= `BRT_CTL_RST;
            byp_q      <= 1'b0;
            tdo_q      <= 1'b0;
            tdo_oe_q   <= 1'b0;
            a_oe_q     <= 18'h0_0000;
            b_oe_q     <= 18'h0_0000;
            tck_prev_q <= 1'b0;
        end else begin
            ack_q      <= ack_d;
            dat_q      <= dat_d;
            op_q       <= op_d;
            run_test_instruction_q     <= run_test_instruction_d;
            sh_io_q    <= sh_io_d;
            sh_ctl_q   <= sh_ctl_d;
            sd_io_q    <= sd_io_d;
            sd_ctl_q   <= sd_ctl_d;
            byp_q      <= byp_d;
            tdo_q      <= tdo_d;
            tdo_oe_q   <= tdo_oe_d;
            a_oe_q     <= a_oe_d;
            b_oe_q     <= b_oe_d;
            tck_prev_q <= tck_s;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
    assign tdo      = tdo_q;
    assign tdo_oe   = tdo_oe_q;
    assign a_out    = sd_io_q.a;
    assign b_out    = sd_io_q.b;
    assign a_oe     = a_oe_q;
    assign b_oe     = b_oe_q;
endmodule

// >>> sim/brt_engine_asserts.sv
// port assertions for the boundary-run test engine
module brt_engine_chk (
    // clock and reset
    input wire logic        ref_clk,
    input wire logic        resetn,
    // wishbone
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // tap levels and pins
    input wire logic        tap_run_idle,
    input wire logic        tap_shift_dr,
    input wire logic        tdo_oe,
    input wire logic [17:0] a_oe,
    input wire logic [17:0] b_oe,
    input wire logic [17:0] a_out,
    input wire logic [17:0] b_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");
    ack_answer_a: assert property ($rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o)
        else $error("ack late");
    unmapped_a: assert property (wb_ack_o && !wb_we_i
        && wb_adr_i[7:2] > 6'h05 |-> wb_dat_o == 32'h0000_0000)
        else $error("unmapped read not zero");
    oe_dir_a: assert property (!(|a_oe && |b_oe))
        else $error("both sides driven");
    oe_group_a: assert property (a_oe inside {18'h0_0000, 18'h3_FFFF}
        && b_oe inside {18'h0_0000, 18'h3_FFFF})
        else $error("split output enables");
    reset_oe_a: assert property ($rose(resetn) |-> a_oe == 18'h0_0000
        && b_oe == 18'h0_0000)
        else $error("pins driven after reset");
    // a write reloads the shadows, so acks are kept out of the window
    freeze_a: assert property ((!tap_run_idle && !wb_ack_o) [*5]
        |=> $stable(a_out) && $stable(b_out))
        else $error("pins moved outside run");
    bypass_oe_a: assert property ($rose(tdo_oe) |-> tap_shift_dr)
        else $error("tdo driven outside shift");
endmodule

bind brt_engine brt_engine_chk u_chk (
    .ref_clk(ref_clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tap_run_idle(tap_run_idle),
    .tap_shift_dr(tap_shift_dr), .tdo_oe(tdo_oe), .a_oe(a_oe), .b_oe(b_oe),
    .a_out(a_out), .b_out(b_out)
);

// >>> sim/brt_tbc.sv
// model of the test bus controller driving tck and tap state levels
module brt_tbc (
    // test clock and serial data
    output logic tck,
    output logic tdi,
    // tap state levels
    output logic run_idle,
    output logic capture_dr,
    output logic shift_dr
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        tck = 1'h0;
        tdi = 1'h0;
        run_idle = 1'h0;
        capture_dr = 1'h0;
        shift_dr = 1'h0;
    end
    // tck moves only inside run, scan and stop; the 7 ns offset keeps its edges
    // off the ref_clk grid so the synchroniser never meets a tie
    task run(input int n);
        #7 run_idle = 1'h1;
        repeat (n) begin
            #160 tck = 1'h1;
            tdi = ~tdi;
            #160 tck = 1'h0;
        end
        #160 run_idle = 1'h0;
    endtask
    // one capture pulse, then one shift pulse carrying b through bypass
    task scan(input logic b);
        #7 capture_dr = 1'h1;
        #160 tck = 1'h1;
        #160 tck = 1'h0;
        #40 capture_dr = 1'h0;
        shift_dr = 1'h1;
        tdi = b;
        #120 tck = 1'h1;
        #160 tck = 1'h0;
        #160 tdi = 1'h0;
    endtask
    // leave shift-dr; the next fall releases tdo
    task stop;
        shift_dr = 1'h0;
        #160 tck = 1'h1;
        #160 tck = 1'h0;
        #160 tdi = 1'h0;
    endtask
endmodule

// >>> sim/tb_top.sv
// self-checking bench for the boundary-run test engine
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk, resetn, cyc, we, ack, tck, tdi, run_idle;
    logic        cap, shf, tdo, tdo_oe;
    logic [7:0]  adr;
    logic [31:0] wdat, rdat, q;
    logic [17:0] a_in, a_out, a_oe, b_in, b_out, b_oe;
    int          err_count, total_checks, cycles, seed;

    initial begin
        ref_clk = 1'h0;
        forever #20 ref_clk = ~ref_clk;
    end
    brt_tbc tbc (.tck(tck), .tdi(tdi), .run_idle(run_idle),
        .capture_dr(cap), .shift_dr(shf));
    // stb shares cyc: a classic single cycle raises both together
    brt_engine dut (.ref_clk(ref_clk), .resetn(resetn), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .tck(tck),
        .tdi(tdi), .tap_run_idle(run_idle), .tap_capture_dr(cap),
        .tap_shift_dr(shf), .tdo(tdo), .tdo_oe(tdo_oe), .a_in(a_in),
        .a_out(a_out), .a_oe(a_oe), .b_in(b_in), .b_out(b_out), .b_oe(b_oe));

    task end_sim;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cycles = cycles + 1;
        if (cycles > 20000) begin
            err_count++;
            end_sim;
        end
    end
    task chk(input logic [35:0] g, input logic [35:0] x);
        total_checks++;
        if (g !== x) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, x);
        end
    endtask
    task wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        @(posedge ref_clk);
        cyc <= 1'h1;
        we <= w;
        adr <= ad;
        wdat <= d;
        do @(posedge ref_clk); while (ack !== 1'h1);
        q = rdat;
        cyc <= 1'h0;
    endtask
    // model cell vector is {output side b, input side a}
    function automatic logic [35:0] nx(input logic [2:0] op,
        input logic [35:0] v, input logic [17:0] p);
        logic [17:0] s;
        s = {v[16:0], v[17] ^ v[10]} ^ p;
        case (op)
            3'h0, 3'h4: return {~v[35:18], p};
            3'h1, 3'h5: return {v[34:0], v[35] ^ v[24]};
            3'h2, 3'h6: return {v[34:0], v[35] ^ v[24]} ^ {18'h0_0000, p};
            3'h3: return {v[34:18], v[35] ^ v[28], s};
            default: return {v[35:18] + 18'h0_0001, s};
        endcase
    endfunction
    task trial(input logic [3:0] c, input logic [35:0] s,
        input logic [11:0] cc, input int n);
        logic [35:0] e;
        logic [17:0] p;
        logic        ok;
        p = 18'($urandom);
        ok = c[3] && cc == 12'h500;
        e = s;
        @(posedge ref_clk);
        a_in <= p;
        b_in <= 18'($urandom);
        wb(1'h1, 8'h08, s[31:0]);
        wb(1'h1, 8'h0C, {16'h0000, cc, s[35:32]});
        wb(1'h1, 8'h00, {28'h000_0000, c});
        for (int k = 0; k < n; k++)
            if (ok) e = nx(c[2:0], e, p);
        tbc.run(n);
        repeat (6) @(posedge ref_clk);
        wb(1'h0, 8'h08, 32'h0000_0000);
        chk({4'h0, q}, {4'h0, e[31:0]});
        wb(1'h0, 8'h0C, 32'h0000_0000);
        chk({20'h0_0000, q[15:0]}, {20'h0_0000, cc, e[35:32]});
        // a 36-bit signature run leaves the shadows on the seed
        chk({b_out, a_oe}, {(c[1:0] == 2'h2 || !ok) ? s[35:18]
            : e[35:18], 18'h0_0000});
        chk({18'h0_0000, b_oe}, {18'h0_0000, ok ? 18'h3_FFFF : 18'h0_0000});
        chk({18'h0_0000, a_out}, {18'h0_0000, s[17:0]});
    endtask

    initial begin
        {resetn, cyc, we, adr, wdat, a_in, b_in} = '0;
        {err_count, total_checks, cycles} = '0;
        seed = $urandom(8);
        repeat (6) @(posedge ref_clk);
        resetn <= 1'h1;
        for (int i = 0; i < 8; i++)
            trial({1'h1, 3'(i)}, 36'({$urandom, $urandom}), 12'h500, 20);
        trial(4'h9, 36'h0_0000_0000, 12'h500, 8);
        trial(4'hB, {18'h0_0000, 18'($urandom)}, 12'h500, 8);
        trial(4'hA, 36'({$urandom, $urandom}), 12'hF00, 8);
        trial(4'hA, 36'({$urandom, $urandom}), 12'h600, 8);
        trial(4'h2, 36'({$urandom, $urandom}), 12'h500, 8);
        wb(1'h1, 8'h00, 32'h0000_0008);
        tbc.scan(1'h1);
        chk({34'h0_0000_0000, tdo, tdo_oe}, 36'h0_0000_0003);
        tbc.stop;
        chk({35'h0_0000_0000, tdo_oe}, 36'h0_0000_0000);
        tbc.scan(1'h0);
        chk({34'h0_0000_0000, tdo, tdo_oe}, 36'h0_0000_0001);
        tbc.stop;
        wb(1'h0, 8'h20, 32'h0000_0000);
        chk({4'h0, q}, 36'h0_0000_0000);
        end_sim;
    end
endmodule
